//--- rtl/rdoc_defs.svh
/*
  Register offsets, field positions, reset values and timebase constants for the
  digital clock trim block. Assumes it is included by bare name from rtl/.
*/
`ifndef RDOC_DEFS_SVH
`define RDOC_DEFS_SVH

// Register offsets on both host ports
`define RDOC_ADDR_TRIM 8'h12
`define RDOC_ADDR_OSC 8'h13
`define RDOC_ADDR_OWNER 8'h16

// Reset values
`define RDOC_TRIM_RST 8'h00
`define RDOC_OSC_RST 8'h00
`define RDOC_OWNER_RST 1'b0

// Oscillator control and owner register fields
`define RDOC_OSC_MODE_BIT 6
`define RDOC_OSC_RSVD_MASK 8'hDF
`define RDOC_OWNER_BIT 0

// Timebase
`define RDOC_SEC_PER_MIN 60
`define RDOC_MIN_PER_HOUR 60
`define RDOC_NORM_PERIOD_HOURS 4
`define RDOC_FAST_PERIOD_MIN 8
`define RDOC_NORM_PERIOD_MIN (`RDOC_NORM_PERIOD_HOURS * `RDOC_MIN_PER_HOUR)
`define RDOC_SEC_LAST 6'(`RDOC_SEC_PER_MIN - 1)
`define RDOC_NORM_MIN_LAST 8'(`RDOC_NORM_PERIOD_MIN - 1)
`define RDOC_FAST_MIN_LAST 8'(`RDOC_FAST_PERIOD_MIN - 1)

// Weight of one trim step, in parts per ten million
`define RDOC_NORM_STEP_PPM_E7 21700
`define RDOC_FAST_STEP_PPM_E7 20345

`endif

//--- rtl/rdoc_pkg.sv
/*
  Types of the digital clock trim block: sequencer states and the state structs
  of both modules. Assumes nothing beyond a SystemVerilog compiler.
*/
package rdoc_pkg;

  // Correction sequencer states, one-hot
  typedef enum logic [1:0] {
    RDOC_IDLE = 2'b01,
    RDOC_RUN = 2'b10
  } rdoc_seq_state_t;

  // Sequencer state
  typedef struct packed {
    rdoc_seq_state_t state;
    logic [7:0] remain;
    logic add_dir;
    logic fast;
    logic pulse_add;
    logic pulse_sub;
  } rdoc_seq_t;

  // Register file and timebase state
  typedef struct packed {
    logic [7:0] trim;
    logic [7:0] osc;
    logic owner;
    logic [7:0] pri_rdata;
    logic [7:0] sec_rdata;
    logic [5:0] sec_cnt;
    logic [7:0] min_cnt;
  } rdoc_regs_t;

endpackage : rdoc_pkg

//--- rtl/rdoc_pulse_gen.sv
/*
  Correction pulse sequencer. Latches trim and mode at a trigger taken while idle, then emits
  one add or remove pulse per step tick until the count is spent.
  Assumes trigger, second and minute strobes are one-cycle pulses on clk_in.
*/
`timescale 1ns/1ps
`include "rdoc_defs.svh"

module rdoc_pulse_gen
  import rdoc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Timebase strobes
  input wire logic trigger_in,
  input wire logic sec_tick_in,
  input wire logic min_tick_in,
  // Settings
  input wire logic [7:0] trim_in,
  input wire logic mode_fast_in,
  // Correction outputs
  output logic corr_add_out,
  output logic corr_sub_out,
  output logic corr_active_out
);

  rdoc_seq_t seq_reg;
  rdoc_seq_t seq_next;
  logic [7:0] magnitude; // Pulse count from the signed trim
  logic step; // Step tick chosen by latched mode

  // Two's complement magnitude; -128 maps to 8'h80 without overflow
  assign magnitude = trim_in[7] ? 8'(~trim_in + 8'h01) : trim_in; // RULE8
  assign step = seq_reg.fast ? sec_tick_in : min_tick_in; // RULE13

  // Next state
  always_comb
  begin
    seq_next = seq_reg;
    seq_next.pulse_add = 1'b0;
    seq_next.pulse_sub = 1'b0;
    case (seq_reg.state)
      RDOC_IDLE:
      begin
        // Settings are sampled only here, so later writes wait for the next trigger
        if (trigger_in && (magnitude != 8'h00)) // RULE14
        begin
          seq_next.add_dir = ~trim_in[7]; // RULE8
          seq_next.fast = mode_fast_in;
          seq_next.remain = 8'(magnitude - 8'h01);
          seq_next.pulse_add = ~trim_in[7]; // RULE9
          seq_next.pulse_sub = trim_in[7]; // RULE9
          seq_next.state = (magnitude == 8'h01) ? RDOC_IDLE : RDOC_RUN; // RULE10
        end
      end
      RDOC_RUN:
      begin
        // One pulse per minute or second; a trigger here is ignored
        if (step) // RULE11
        begin
          seq_next.pulse_add = seq_reg.add_dir;
          seq_next.pulse_sub = ~seq_reg.add_dir;
          seq_next.remain = 8'(seq_reg.remain - 8'h01);
          if (seq_reg.remain == 8'h01)
          begin
            seq_next.state = RDOC_IDLE;
          end
        end
      end
      default:
      begin
        seq_next.state = RDOC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      seq_reg <= '{state: RDOC_IDLE, remain: 8'h00, add_dir: 1'b0, fast: 1'b0,
                   pulse_add: 1'b0, pulse_sub: 1'b0};
    end
    else
    begin
      seq_reg <= seq_next;
    end
  end

  // Pulses are flops; activity covers the whole sequence
  assign corr_add_out = seq_reg.pulse_add;
  assign corr_sub_out = seq_reg.pulse_sub;
  assign corr_active_out = (seq_reg.state == RDOC_RUN) | seq_reg.pulse_add | seq_reg.pulse_sub; // RULE12

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_pulse_excl;
    !(corr_add_out && corr_sub_out);
  endproperty
  a_pulse_excl: assert property (p_pulse_excl) else $error("add and remove pulses together"); // RULE9

  property p_trig_pulse;
    (seq_reg.state == RDOC_IDLE) && trigger_in && (magnitude != 8'h00) && trim_in[7] |=> corr_sub_out && !corr_add_out;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("negative trim gave no remove pulse"); // RULE8

  property p_idle_quiet;
    (seq_reg.state == RDOC_IDLE) && !trigger_in |=> !corr_add_out && !corr_sub_out;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pulse without trigger"); // RULE10

  property p_fast_step;
    (seq_reg.state == RDOC_RUN) && seq_reg.fast && sec_tick_in |=> corr_add_out || corr_sub_out;
  endproperty
  a_fast_step: assert property (p_fast_step) else $error("fast mode missed a second pulse"); // RULE13

  property p_norm_hold;
    (seq_reg.state == RDOC_RUN) && !seq_reg.fast && !min_tick_in |=> !corr_add_out && !corr_sub_out;
  endproperty
  a_norm_hold: assert property (p_norm_hold) else $error("normal mode pulsed off a minute"); // RULE11

  // A trigger inside a run only steps it; direction and mode stay latched, the count drops by one
  property p_no_retrigger;
    (seq_reg.state == RDOC_RUN) && trigger_in |=> $stable(seq_reg.add_dir) && $stable(seq_reg.fast)
      && (seq_reg.remain == 8'($past(seq_reg.remain) - 8'h01));
  endproperty
  a_no_retrigger: assert property (p_no_retrigger) else $error("trigger disturbed running sequence"); // RULE14

  c_run_fast: cover property ((seq_reg.state == RDOC_RUN) && seq_reg.fast ##1 corr_add_out);
  c_run_norm_sub: cover property ((seq_reg.state == RDOC_RUN) && !seq_reg.fast ##1 corr_sub_out);

endmodule : rdoc_pulse_gen

//--- rtl/rdoc_top.sv
/*
  Digital clock trim block: trim and oscillator control registers on two host
  ports with write ownership, a second/minute timebase and the pulse sequencer.
  Assumes both host ports and the one-second strobe are synchronous to clk_in,
  and that the second strobe comes from the crystal domain once per second.
*/
//
// Contract
// [RULE1] Trim register at 12h, resets to 00h
// [RULE2] Owner bit picks which port writes trim
// [RULE3] Only the primary port changes the owner bit
// [RULE4] Mode select is bit 6 of 13h
// [RULE5] Mode 0 corrects every four hours
// [RULE6] Mode 1 corrects every eight minutes
// [RULE7] Host waits 135 ms between trim writes
// [RULE8] Trim is signed, +127 down to -128
// [RULE9] Correction adds or removes pulses, oscillator untouched
// [RULE10] Normal mode: one pulse per minute after trigger
// [RULE11] Long counts run on into following hours
// [RULE12] Correction activity is visible on an output
// [RULE13] Fast mode: one pulse per second after trigger
// [RULE14] New settings wait for the next trigger
`timescale 1ns/1ps
`include "rdoc_defs.svh"

module rdoc_top
  import rdoc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Primary host port
  input wire logic pri_wr_in,
  input wire logic [7:0] pri_addr_in,
  input wire logic [7:0] pri_wdata_in,
  output logic [7:0] pri_rdata_out,
  // Secondary host port
  input wire logic sec_wr_in,
  input wire logic [7:0] sec_addr_in,
  input wire logic [7:0] sec_wdata_in,
  output logic [7:0] sec_rdata_out,
  // Timebase from the crystal domain
  input wire logic sec_tick_in,
  // Correction and oscillator control
  output logic corr_add_out,
  output logic corr_sub_out,
  output logic corr_active_out,
  output logic [7:0] osc_ctrl_out
);

  rdoc_regs_t regs_reg;
  rdoc_regs_t regs_next;
  logic min_tick; // Strobe on entry to a new minute
  logic trigger; // Strobe at the start of a correction period
  logic mode_fast; // Correction mode select
  logic pri_trim_wr; // Accepted trim write, primary
  logic sec_trim_wr; // Accepted trim write, secondary
  logic pri_osc_wr; // Accepted oscillator write, primary
  logic sec_osc_wr; // Accepted oscillator write, secondary

  // Mode is read live for the period choice; the sequencer keeps its own latched copy
  assign mode_fast = regs_reg.osc[`RDOC_OSC_MODE_BIT]; // RULE4

  // Ownership gating; the refused port's write is dropped silently
  // An owner write lands at its own edge, so the gating flips for the next cycle
  assign pri_trim_wr = pri_wr_in && (pri_addr_in == `RDOC_ADDR_TRIM) && regs_reg.owner; // RULE2
  assign sec_trim_wr = sec_wr_in && (sec_addr_in == `RDOC_ADDR_TRIM) && !regs_reg.owner; // RULE2
  assign pri_osc_wr = pri_wr_in && (pri_addr_in == `RDOC_ADDR_OSC) && regs_reg.owner;
  assign sec_osc_wr = sec_wr_in && (sec_addr_in == `RDOC_ADDR_OSC) && !regs_reg.owner;

  // Minute boundary and period start, both on the last second's strobe
  assign min_tick = sec_tick_in && (regs_reg.sec_cnt == `RDOC_SEC_LAST);
  always_comb
  begin
    if (mode_fast)
    begin
      // 240 is a multiple of 8, so one minute counter serves both modes
      trigger = min_tick && ((regs_reg.min_cnt % 8'(`RDOC_FAST_PERIOD_MIN)) == `RDOC_FAST_MIN_LAST); // RULE6
    end
    else
    begin
      trigger = min_tick && (regs_reg.min_cnt == `RDOC_NORM_MIN_LAST); // RULE5
    end
  end

  // Register file and timebase next state
  always_comb
  begin
    regs_next = regs_reg;
    // Trim; only one port can hold ownership, so no write collision
    if (pri_trim_wr)
    begin
      regs_next.trim = pri_wdata_in; // RULE1
    end
    else if (sec_trim_wr)
    begin
      regs_next.trim = sec_wdata_in; // RULE1
    end
    // Oscillator control; reserved bit 5 kept at zero
    if (pri_osc_wr)
    begin
      regs_next.osc = pri_wdata_in & `RDOC_OSC_RSVD_MASK; // RULE4
    end
    else if (sec_osc_wr)
    begin
      regs_next.osc = sec_wdata_in & `RDOC_OSC_RSVD_MASK; // RULE4
    end
    // Owner bit: secondary writes to it are ignored
    if (pri_wr_in && (pri_addr_in == `RDOC_ADDR_OWNER))
    begin
      regs_next.owner = pri_wdata_in[`RDOC_OWNER_BIT]; // RULE3
    end
    // Read data, one cycle after the address
    // Reads have no side effects, so both ports may read at any time
    case (pri_addr_in)
      `RDOC_ADDR_TRIM: regs_next.pri_rdata = regs_reg.trim;
      `RDOC_ADDR_OSC: regs_next.pri_rdata = regs_reg.osc;
      `RDOC_ADDR_OWNER: regs_next.pri_rdata = {7'h00, regs_reg.owner};
      default: regs_next.pri_rdata = 8'h00;
    endcase
    case (sec_addr_in)
      `RDOC_ADDR_TRIM: regs_next.sec_rdata = regs_reg.trim;
      `RDOC_ADDR_OSC: regs_next.sec_rdata = regs_reg.osc;
      `RDOC_ADDR_OWNER: regs_next.sec_rdata = {7'h00, regs_reg.owner};
      default: regs_next.sec_rdata = 8'h00;
    endcase
    // Seconds and minutes within the four-hour period
    // Register writes never touch these counters, so a mode change keeps the phase
    // A missed second strobe stretches the period; nothing here can recover it
    if (sec_tick_in)
    begin
      if (min_tick)
      begin
        regs_next.sec_cnt = 6'h00;
        regs_next.min_cnt = (regs_reg.min_cnt == `RDOC_NORM_MIN_LAST) ? 8'h00 : 8'(regs_reg.min_cnt + 8'h01);
      end
      else
      begin
        regs_next.sec_cnt = 6'(regs_reg.sec_cnt + 6'h01);
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      regs_reg <= '{trim: `RDOC_TRIM_RST, osc: `RDOC_OSC_RST, owner: `RDOC_OWNER_RST,
                    pri_rdata: 8'h00, sec_rdata: 8'h00, sec_cnt: 6'h00, min_cnt: 8'h00};
    end
    else
    begin
      regs_reg <= regs_next;
    end
  end

  // Pulse sequencer; pulses go to the divider chain, not the oscillator
  // Trim reaches it live; it latches the value only at a trigger
  rdoc_pulse_gen u_pulse_gen (
    .clk_in(clk_in),
    .resetn_in(resetn_in),
    .trigger_in(trigger),
    .sec_tick_in(sec_tick_in),
    .min_tick_in(min_tick),
    .trim_in(regs_reg.trim),
    .mode_fast_in(mode_fast),
    .corr_add_out(corr_add_out),
    .corr_sub_out(corr_sub_out),
    .corr_active_out(corr_active_out)
  ); // RULE9

  // Outputs straight from flops
  assign pri_rdata_out = regs_reg.pri_rdata;
  assign sec_rdata_out = regs_reg.sec_rdata;
  assign osc_ctrl_out = regs_reg.osc;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  property p_sec_owner;
    sec_wr_in && (sec_addr_in == `RDOC_ADDR_OWNER) && !(pri_wr_in && (pri_addr_in == `RDOC_ADDR_OWNER))
      |=> $stable(regs_reg.owner);
  endproperty
  a_sec_owner: assert property (p_sec_owner) else $error("secondary port changed owner bit"); // RULE3

  property p_pri_trim_ro;
    pri_wr_in && (pri_addr_in == `RDOC_ADDR_TRIM) && !regs_reg.owner && !sec_trim_wr |=> $stable(regs_reg.trim);
  endproperty
  a_pri_trim_ro: assert property (p_pri_trim_ro) else $error("primary wrote trim without ownership"); // RULE2

  property p_sec_trim_rw;
    sec_wr_in && (sec_addr_in == `RDOC_ADDR_TRIM) && !regs_reg.owner ##2 (sec_addr_in == `RDOC_ADDR_TRIM)
      |=> sec_rdata_out == $past(sec_wdata_in, 3);
  endproperty
  a_sec_trim_rw: assert property (p_sec_trim_rw) else $error("secondary trim write not read back"); // RULE1

  property p_norm_period;
    trigger && !mode_fast |-> (regs_reg.min_cnt == `RDOC_NORM_MIN_LAST) && (regs_reg.sec_cnt == `RDOC_SEC_LAST);
  endproperty
  a_norm_period: assert property (p_norm_period) else $error("normal trigger off the four-hour mark"); // RULE5

  property p_fast_period;
    trigger && mode_fast |-> (regs_reg.min_cnt[2:0] == 3'h7) && sec_tick_in;
  endproperty
  a_fast_period: assert property (p_fast_period) else $error("fast trigger off the eight-minute mark"); // RULE6

  property p_active;
    (corr_add_out || corr_sub_out) |-> corr_active_out;
  endproperty
  a_active: assert property (p_active) else $error("pulse without activity flag"); // RULE12

  // Activity may only drop right after the last pulse of a sequence
  property p_active_end;
    $fell(corr_active_out) |-> $past(corr_add_out || corr_sub_out);
  endproperty
  a_active_end: assert property (p_active_end) else $error("activity ended without a final pulse"); // RULE12

  // The minute count wraps at the end of each four-hour period
  property p_min_wrap;
    min_tick && (regs_reg.min_cnt == `RDOC_NORM_MIN_LAST) |=> regs_reg.min_cnt == 8'h00;
  endproperty
  a_min_wrap: assert property (p_min_wrap) else $error("minute count missed its wrap"); // RULE5

  c_owner_swap: cover property (pri_wr_in && (pri_addr_in == `RDOC_ADDR_OWNER) ##1 regs_reg.owner);
  c_fast_trigger: cover property (trigger && mode_fast);

endmodule : rdoc_top

//--- tb/rdoc_host_model.sv
/*
  Host port model: one register port of the trim block, byte writes and reads.
  Assumes a free-running clk_in and one task call at a time per instance.
*/
`timescale 1ns/1ps
`include "rdoc_defs.svh"

module rdoc_host_model #(parameter int GAP_CYC = 40)
(
  // Clock
  input wire logic clk_in,
  // Port towards the block
  output logic wr_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out,
  input wire logic [7:0] rdata_in
);
  int cyc = 0; // Free-running cycle count
  int last_cfg = -GAP_CYC; // Cycle of the last trim or mode write

  // Idle port at time zero
  initial
  begin
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // Time base for write spacing
  always @(posedge clk_in)
    cyc <= cyc + 1;

  // One byte write; settings writes keep a scaled minimum spacing
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    while ((a == `RDOC_ADDR_TRIM || a == `RDOC_ADDR_OSC) && cyc - last_cfg < GAP_CYC)
      @(posedge clk_in);
    @(posedge clk_in);
    #1 wr_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1 wr_out = 1'b0;
    // Released data shows no stale byte
    wdata_out = ~d;
    if (a == `RDOC_ADDR_TRIM || a == `RDOC_ADDR_OSC)
      last_cfg = cyc;
  endtask : wr

  // Read: address held, data registered one cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1 addr_out = a;
    repeat (2) @(posedge clk_in);
    #1 d = rdata_in;
  endtask : rd
endmodule : rdoc_host_model

//--- tb/tb_top.sv
/*
  Self-checking bench for the trim block: register ownership and correction runs.
  Assumes the block and two host port models; sec_tick_in is made here.
*/
`timescale 1ns/1ps
`include "rdoc_defs.svh"

module tb_top;
  // Clock, reset and second strobe
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sec_tick_in = 1'b0;
  // Host port nets
  logic pri_wr, sec_wr;
  logic [7:0] pri_addr, pri_wdata, pri_rdata, sec_addr, sec_wdata, sec_rdata;
  // Block outputs
  logic corr_add, corr_sub, corr_active;
  logic [7:0] osc_ctrl;
  // Scoreboard
  int error_cnt = 0;
  int cmp_count = 0;
  int tick_idx = 0, n_pul = 0, first_idx = 0, last_idx = 0, step = 1;
  logic prev_tick = 1'b0;
  logic exp_add = 1'b1;
  logic [7:0] rd_val;

  always #5 clk_in = ~clk_in;

  rdoc_top u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .pri_wr_in(pri_wr), .pri_addr_in(pri_addr),
    .pri_wdata_in(pri_wdata), .pri_rdata_out(pri_rdata), .sec_wr_in(sec_wr), .sec_addr_in(sec_addr),
    .sec_wdata_in(sec_wdata), .sec_rdata_out(sec_rdata), .sec_tick_in(sec_tick_in),
    .corr_add_out(corr_add), .corr_sub_out(corr_sub), .corr_active_out(corr_active), .osc_ctrl_out(osc_ctrl));
  rdoc_host_model #(.GAP_CYC(40)) u_pri (.clk_in(clk_in), .wr_out(pri_wr), .addr_out(pri_addr),
    .wdata_out(pri_wdata), .rdata_in(pri_rdata));
  rdoc_host_model #(.GAP_CYC(40)) u_sec (.clk_in(clk_in), .wr_out(sec_wr), .addr_out(sec_addr),
    .wdata_out(sec_wdata), .rdata_in(sec_rdata));

  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Closing report
  task automatic give_verdict;
    $display("counts: compares=%0d mismatches=%0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Pulse count of a signed trim byte
  function automatic int mag(input logic [7:0] t);
    return t[7] ? 256 - int'(t) : int'(t);
  endfunction : mag

  // Pulse monitor; a pulse lands one cycle after its strobe
  always @(posedge clk_in)
  begin
    if (corr_add || corr_sub)
    begin
      if (n_pul == 0)
        first_idx = tick_idx;
      else
        check(16'(tick_idx - last_idx), 16'(step));
      check({15'h0, prev_tick}, 16'h0001);
      check({13'h0, corr_add, corr_sub, corr_active}, {13'h0, exp_add, ~exp_add, 1'b1});
      last_idx = tick_idx;
      n_pul++;
    end
    if (sec_tick_in)
      tick_idx++;
    prev_tick = sec_tick_in;
  end

  // Second strobes, one every other cycle to keep the run short
  task automatic run_ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_in);
      #1 sec_tick_in = 1'b1;
      @(posedge clk_in);
      #1 sec_tick_in = 1'b0;
    end
  endtask : run_ticks

  // Program trim and mode, then run past the next trigger and its sequence
  task automatic run_case(input logic [7:0] t, input logic m);
    int per;
    int trig;
    u_pri.wr(`RDOC_ADDR_TRIM, t);
    u_pri.wr(`RDOC_ADDR_OSC, {1'b0, m, 6'h00});
    per = m ? `RDOC_FAST_PERIOD_MIN * `RDOC_SEC_PER_MIN : `RDOC_NORM_PERIOD_MIN * `RDOC_SEC_PER_MIN;
    step = m ? 1 : `RDOC_SEC_PER_MIN;
    exp_add = ~t[7];
    n_pul = 0;
    trig = (tick_idx / per + 1) * per;
    run_ticks(trig - tick_idx + mag(t) * step + 4);
    check(16'(n_pul), 16'(mag(t)));
    check(16'(first_idx), 16'(trig));
    check({15'h0, corr_active}, 16'h0000);
    $display("test trim=%h mode=%0d done", t, m);
  endtask : run_case

  // Read through one port and compare
  task automatic rdchk(input bit p, input logic [7:0] a, input logic [7:0] e);
    if (p)
      u_pri.rd(a, rd_val);
    else
      u_sec.rd(a, rd_val);
    check({8'h00, rd_val}, {8'h00, e});
  endtask : rdchk

  // Main sequence
  initial
  begin
    void'($urandom(15559));
    repeat (2) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    rdchk(1, `RDOC_ADDR_TRIM, `RDOC_TRIM_RST);
    rdchk(0, `RDOC_ADDR_OSC, `RDOC_OSC_RST);
    rdchk(0, `RDOC_ADDR_OWNER, 8'h00);
    rdchk(1, 8'h20, 8'h00);
    u_sec.wr(`RDOC_ADDR_TRIM, 8'h5A);
    u_pri.wr(`RDOC_ADDR_TRIM, 8'h33);
    rdchk(1, `RDOC_ADDR_TRIM, 8'h5A);
    u_sec.wr(`RDOC_ADDR_OWNER, 8'h01);
    rdchk(1, `RDOC_ADDR_OWNER, 8'h00);
    u_pri.wr(`RDOC_ADDR_OWNER, 8'h01);
    u_sec.wr(`RDOC_ADDR_TRIM, 8'h11);
    rdchk(0, `RDOC_ADDR_OWNER, 8'h01);
    rdchk(0, `RDOC_ADDR_TRIM, 8'h5A);
    u_pri.wr(`RDOC_ADDR_TRIM, 8'hC3);
    rdchk(0, `RDOC_ADDR_TRIM, 8'hC3);
    u_pri.wr(`RDOC_ADDR_OSC, 8'hFF);
    rdchk(0, `RDOC_ADDR_OSC, 8'hDF);
    check({8'h00, osc_ctrl}, 16'h00DF);
    $display("test registers done");
    run_case(8'($urandom_range(255, 1)), 1'b1);
    run_case(8'h7F, 1'b1);
    // A trim write in mid-run must not cut the running sequence short
    fork
      run_case(8'h80, 1'b1);
      begin
        wait (n_pul == 10);
        u_pri.wr(`RDOC_ADDR_TRIM, 8'h01);
      end
    join
    run_case(8'hFF, 1'b1);
    // Mode and trim changed in mid-run, so fast triggers land inside the running sequence
    fork
      run_case(8'h80, 1'b0);
      begin
        wait (n_pul == 10);
        u_pri.wr(`RDOC_ADDR_OSC, 8'h40);
        u_pri.wr(`RDOC_ADDR_TRIM, 8'h00);
      end
    join
    give_verdict;
  end

  // Watchdog, well beyond the expected run length
  initial
  begin
    #900000;
    error_cnt++;
    give_verdict;
  end
endmodule : tb_top
